// *** src/pidp_pkg.sv ***
// package: offsets, field positions, reset values and codes of the paged id and vendor register set
package pidp_pkg;
  // register address width and data width
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // base register that holds the page selector, and the selector field position
  localparam logic [3:0] BASE_PAGE_REG = 4'h7;
  localparam int unsigned PAGE_SEL_LSB = 5;
  localparam logic [2:0] PAGE_SEL_RESET = 3'h0;
  // page numbers
  localparam logic [2:0] PAGE_ID = 3'h1;
  localparam logic [2:0] PAGE_VENDOR = 3'h7;
  // paged offsets
  localparam logic [3:0] OFF_COMPLIANCE_LEVEL = 4'h8;
  localparam logic [3:0] OFF_ID_PAGE_RESERVED = 4'h9;
  localparam logic [3:0] OFF_MAKER_CODE_HIGH = 4'ha;
  localparam logic [3:0] OFF_MAKER_CODE_MID = 4'hb;
  localparam logic [3:0] OFF_MAKER_CODE_LOW = 4'hc;
  localparam logic [3:0] OFF_PART_CODE_HIGH = 4'hd;
  localparam logic [3:0] OFF_PART_CODE_MID = 4'he;
  localparam logic [3:0] OFF_PART_CODE_LOW = 4'hf;
  localparam logic [3:0] OFF_SOFT_RESET = 4'he;
  // soft hard reset bit position
  localparam int unsigned SOFT_RESET_BIT = 0;
  // compliance level value
  localparam logic [7:0] COMPLIANCE_LEVEL_VAL = 8'h02;
  // identity codes: arbitrary neutral values
  localparam logic [23:0] MAKER_CODE_DEFAULT = 24'h12_34_56;
  localparam logic [23:0] PART_CODE_DEFAULT = 24'h65_43_21;
  // length of the internal hard reset pulse in cycles
  localparam int unsigned SOFT_RESET_CYCLES = 4;
  // link protocol modes
  typedef enum logic [1:0] {
    PIDP_LINK_A = 2'b01,
    PIDP_LINK_B = 2'b10
  } pidp_link_mode_t;
endpackage : pidp_pkg

// *** src/pidp_bus_if.sv ***
// interface: register bus between the top module and the paged register file
`timescale 1ns/1ps
`default_nettype none
interface pidp_bus_if;
  logic [3:0] addr; // register address
  logic [7:0] wdata; // write data
  logic wr; // write strobe
  logic rd; // read strobe
  logic [7:0] rdata; // read data, cycle after rd
  logic soft_reset; // one-cycle soft hard reset request
  logic [2:0] page; // current page selector
  modport host (output addr, output wdata, output wr, output rd, input rdata, input soft_reset, input page);
  modport regs (input addr, input wdata, input wr, input rd, output rdata, output soft_reset, output page);
endinterface : pidp_bus_if
`default_nettype wire

// *** src/pidp_regs.sv ***
// paged register file: base page selector, id page and vendor page
`timescale 1ns/1ps
`default_nettype none
module pidp_regs
  import pidp_pkg::*;
#(
  parameter logic [23:0] MAKER_CODE = MAKER_CODE_DEFAULT, // arbitrary value
  parameter logic [23:0] PART_CODE = PART_CODE_DEFAULT // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  pidp_bus_if.regs bus
);
  // page selector register and read data register
  logic [2:0] page_r;
  logic [7:0] rdata_r;
  logic swr_r;
  // decode of writes
  wire base_wr = bus.wr && (bus.addr == BASE_PAGE_REG);
  wire vend_pg = (page_r == PAGE_VENDOR);
  wire id_pg = (page_r == PAGE_ID);
  wire swr_wr = bus.wr && vend_pg && (bus.addr == OFF_SOFT_RESET) && bus.wdata[SOFT_RESET_BIT];
  // id page read mux
  logic [7:0] id_data;
  always_comb begin
    id_data = 8'h00;
    unique case (bus.addr)
      OFF_COMPLIANCE_LEVEL: id_data = COMPLIANCE_LEVEL_VAL;
      OFF_MAKER_CODE_HIGH: id_data = MAKER_CODE[23:16];
      OFF_MAKER_CODE_MID: id_data = MAKER_CODE[15:8];
      OFF_MAKER_CODE_LOW: id_data = MAKER_CODE[7:0];
      OFF_PART_CODE_HIGH: id_data = PART_CODE[23:16];
      OFF_PART_CODE_MID: id_data = PART_CODE[15:8];
      OFF_PART_CODE_LOW: id_data = PART_CODE[7:0];
      default: id_data = 8'h00; // reserved reads zero
    endcase
  end
  // vendor page reads zero everywhere: test space and soft reset bit
  wire [7:0] vend_data = 8'h00;
  wire [7:0] base_data = (bus.addr == BASE_PAGE_REG) ? {page_r, 5'h00} : 8'h00;
  wire paged = bus.addr[3];
  wire [7:0] rd_nxt = !paged ? base_data : id_pg ? id_data : vend_pg ? vend_data : 8'h00;
  // page selector; software reset returns it to default
  always_ff @(posedge clk) begin
    if (rst) begin
      page_r <= PAGE_SEL_RESET;
    end else if (base_wr) begin
      page_r <= bus.wdata[PAGE_SEL_LSB +: 3];
    end
  end
  // read data held one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= bus.rd ? rd_nxt : 8'h00;
    end
  end
  // soft reset request pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      swr_r <= 1'b0;
    end else begin
      swr_r <= swr_wr;
    end
  end
  assign bus.rdata = rdata_r;
  assign bus.soft_reset = swr_r;
  assign bus.page = page_r;
  // checks
  a_swr_reads_zero: assert property (@(posedge clk) disable iff (rst)
    bus.rd && vend_pg && bus.addr == OFF_SOFT_RESET |=> rdata_r == 8'h00) else $error("soft reset bit read nonzero");
  a_compliance_val: assert property (@(posedge clk) disable iff (rst)
    bus.rd && id_pg && bus.addr == OFF_COMPLIANCE_LEVEL |=> rdata_r == 8'h02) else $error("compliance level wrong");
  a_maker_high: assert property (@(posedge clk) disable iff (rst)
    bus.rd && id_pg && bus.addr == OFF_MAKER_CODE_HIGH |=> rdata_r == MAKER_CODE[23:16]) else $error("maker byte wrong");
  a_part_high: assert property (@(posedge clk) disable iff (rst)
    bus.rd && id_pg && bus.addr == OFF_PART_CODE_HIGH |=> rdata_r == PART_CODE[23:16]) else $error("part byte wrong");
  a_id_reserved: assert property (@(posedge clk) disable iff (rst)
    bus.rd && id_pg && bus.addr == OFF_ID_PAGE_RESERVED |=> rdata_r == 8'h00) else $error("reserved nonzero");
  a_vend_select: assert property (@(posedge clk) disable iff (rst)
    base_wr && bus.wdata[7:5] == 3'h7 |=> page_r == PAGE_VENDOR) else $error("vendor page not selected");
  a_id_select: assert property (@(posedge clk) disable iff (rst)
    base_wr && bus.wdata[7:5] == 3'h1 |=> page_r == PAGE_ID) else $error("id page not selected");
  a_test_space: assert property (@(posedge clk) disable iff (rst)
    bus.rd && vend_pg && paged |=> rdata_r == 8'h00) else $error("test space nonzero");
  c_id_read: cover property (@(posedge clk) bus.rd && id_pg && paged);
  c_vend_sel: cover property (@(posedge clk) base_wr && bus.wdata[7:5] == 3'h7);
  c_swr: cover property (@(posedge clk) swr_wr);
endmodule : pidp_regs
`default_nettype wire

// *** src/pidp_top.sv ***
// top: paged id and vendor register set with soft hard reset and link protocol select
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - page selector 7 shows vendor page
// - page selector 1 shows id page
// - offset 8 reads compliance 02h
// - maker code bytes at a, b, c
// - part code bytes at d, e, f
// - writing 1 to vendor bit0 hard-resets
// - soft reset bit always reads zero
// - select low runs 1394a link protocol
// - select high runs 1394b link protocol
// - select leaves cable port mode alone
// - select low disables bus owner arbitration
module pidp_top
  import pidp_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = SOFT_RESET_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic LINK_PROTOCOL_SELECT,
  input wire logic LINK_REQUEST_LINE,
  input wire logic CABLE_MODE_IN,
  output logic LINK_B_MODE,
  output logic BUS_OWNER_ARBITRATION_EN,
  output logic LINK_REQUEST_SEEN,
  output logic CABLE_MODE,
  output logic HARD_RESET_ACTIVE,
  output logic [2:0] PAGE
);
  // internal hard reset: pin or software-triggered pulse
  logic [3:0] swr_cnt_r;
  logic [3:0] swr_cnt_nxt;
  logic int_rst;
  pidp_bus_if bus ();
  assign bus.addr = ADDR;
  assign bus.wdata = WDATA;
  assign bus.wr = WR;
  assign bus.rd = RD;
  // counter restarts on a soft reset request and counts down to release
  assign swr_cnt_nxt = bus.soft_reset ? RESET_CYCLES[3:0] : (swr_cnt_r != 4'h0) ? swr_cnt_r - 4'h1 : 4'h0;
  assign int_rst = RESET || (swr_cnt_r != 4'h0);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      swr_cnt_r <= 4'h0;
    end else begin
      swr_cnt_r <= swr_cnt_nxt;
    end
  end
  // register file under the combined reset
  pidp_regs u_regs (
    .clk(CLK),
    .rst(int_rst),
    .bus(bus)
  );
  // link mode decode: only the link side looks at the select pin
  pidp_link_mode_t mode_nxt;
  assign mode_nxt = LINK_PROTOCOL_SELECT ? PIDP_LINK_B : PIDP_LINK_A;
  // registered outputs
  always_ff @(posedge CLK) begin
    if (int_rst) begin
      LINK_B_MODE <= 1'b0;
      BUS_OWNER_ARBITRATION_EN <= 1'b0;
      LINK_REQUEST_SEEN <= 1'b0;
      CABLE_MODE <= 1'b0;
      HARD_RESET_ACTIVE <= 1'b1;
    end else begin
      LINK_B_MODE <= (mode_nxt == PIDP_LINK_B);
      BUS_OWNER_ARBITRATION_EN <= (mode_nxt == PIDP_LINK_B);
      LINK_REQUEST_SEEN <= LINK_REQUEST_LINE; // request started by the link
      CABLE_MODE <= CABLE_MODE_IN; // independent of select
      HARD_RESET_ACTIVE <= 1'b0;
    end
  end
  assign RDATA = bus.rdata;
  assign PAGE = bus.page;
  // request pulse loads the counter one edge later, the output flop follows one edge after that
  a_soft_reset_hold: assert property (@(posedge CLK) disable iff (RESET)
    bus.soft_reset |-> ##2 HARD_RESET_ACTIVE [*4]) else $error("soft reset not applied");
  a_soft_release: assert property (@(posedge CLK) disable iff (RESET)
    bus.soft_reset ##1 !bus.soft_reset [*6] |-> !HARD_RESET_ACTIVE) else $error("soft reset stuck");
  a_bus_owner_arbitration_off_a: assert property (@(posedge CLK) disable iff (int_rst)
    !LINK_PROTOCOL_SELECT |=> !BUS_OWNER_ARBITRATION_EN || int_rst) else $error("arbitration on in a mode");
  // the reset level is taken as sampled, so a release edge does not count as a mode edge
  a_mode_b: assert property (@(posedge CLK) disable iff (RESET)
    !int_rst && LINK_PROTOCOL_SELECT |=> LINK_B_MODE) else $error("b mode missing");
  // cable side copy follows its own pin only
  a_cable_copy: assert property (@(posedge CLK) disable iff (RESET)
    !int_rst |=> CABLE_MODE == $past(CABLE_MODE_IN)) else $error("cable mode not passed on");
  // link request passed on one cycle late
  a_req_copy: assert property (@(posedge CLK) disable iff (RESET)
    !int_rst |=> LINK_REQUEST_SEEN == $past(LINK_REQUEST_LINE)) else $error("link request not passed on");
  // any reset, pin or software, is flagged on the next cycle
  a_reset_flag: assert property (@(posedge CLK)
    int_rst |=> HARD_RESET_ACTIVE) else $error("hard reset flag missing");
  c_mode_b: cover property (@(posedge CLK) LINK_B_MODE);
  c_soft_reset: cover property (@(posedge CLK) bus.soft_reset);
endmodule : pidp_top
`default_nettype wire

// *** sim/pidp_link_model.sv ***
// link controller model: drives the link request line when told to
`timescale 1ns/1ps
`default_nettype none
module pidp_link_model (
  input wire logic clk,
  input wire logic go,
  output logic req
);
  // toggling stream while asked, idle low otherwise
  always @(posedge clk) begin
    req <= go ? ~req : 1'b0;
  end
endmodule : pidp_link_model
`default_nettype wire

// *** sim/pidp_top_tb_top.sv ***
// testbench: register pages, soft hard reset and link protocol pins
`timescale 1ns/1ps
`default_nettype none
module pidp_top_tb_top import pidp_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic sel = 1'b0, cab = 1'b0, go = 1'b0, req; // pin levels and model control
  logic lbm, arb, seen, cmode, hra;
  logic [2:0] page;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [7:0] d;
  always #5 clk = ~clk;
  pidp_link_model link (.clk(clk), .go(go), .req(req));
  pidp_top DUT (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LINK_PROTOCOL_SELECT(sel), .LINK_REQUEST_LINE(req), .CABLE_MODE_IN(cab), .LINK_B_MODE(lbm),
    .BUS_OWNER_ARBITRATION_EN(arb), .LINK_REQUEST_SEEN(seen), .CABLE_MODE(cmode),
    .HARD_RESET_ACTIVE(hra), .PAGE(page));
  // single compare point, counts every check
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // one-cycle read strobe, data sampled in the following cycle only
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // id page contents, reserved slot included
  task automatic t_id_page();
    logic [7:0] exp [8];
    exp = '{COMPLIANCE_LEVEL_VAL, 8'h00, MAKER_CODE_DEFAULT[23:16], MAKER_CODE_DEFAULT[15:8],
      MAKER_CODE_DEFAULT[7:0], PART_CODE_DEFAULT[23:16], PART_CODE_DEFAULT[15:8], PART_CODE_DEFAULT[7:0]};
    bus_wr(BASE_PAGE_REG, {PAGE_ID, 5'h00});
    #1 chk(page, PAGE_ID);
    for (int i = 0; i < 8; i++) begin
      bus_rd(4'h8 + 4'(i));
      chk(d, exp[i]);
    end
  endtask : t_id_page
  // vendor page: reads zero, then the soft hard reset
  task automatic t_vendor();
    int n;
    bus_wr(BASE_PAGE_REG, {PAGE_VENDOR, 5'h00});
    #1 chk(page, PAGE_VENDOR);
    bus_wr(OFF_SOFT_RESET, 8'h00);
    bus_rd(OFF_SOFT_RESET);
    chk(d, 8'h00);
    bus_rd(4'h9);
    chk(d, 8'h00);
    bus_wr(OFF_SOFT_RESET, 8'h01);
    n = 0;
    while (hra !== 1'b1 && n < 10) begin @(posedge clk); #1 n++; end
    chk(hra, 1'b1);
    n = 0;
    while (hra !== 1'b0 && n < 20) begin @(posedge clk); #1 n++; end
    chk(hra, 1'b0);
    chk(page, PAGE_SEL_RESET);
    bus_rd(OFF_COMPLIANCE_LEVEL);
    chk(d, 8'h00);
  endtask : t_vendor
  // protocol pin sets link mode and arbitration enable, not cable mode; requests are passed on
  task automatic t_link();
    logic p;
    @(posedge clk);
    sel <= 1'b0; cab <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(lbm, 1'b0);
    chk(arb, 1'b0);
    chk(cmode, 1'b1);
    @(posedge clk);
    sel <= 1'b1; go <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({lbm, arb}, 2'b11);
    chk(cmode, 1'b1);
    repeat (4) begin
      p = req;
      @(posedge clk);
      #1 chk(seen, p);
    end
    go <= 1'b0;
  endtask : t_link
  // verdict and end of run
  task automatic summarize();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (7) @(posedge clk);
    #1 chk(hra, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(page, PAGE_SEL_RESET);
    chk(hra, 1'b0);
    t_id_page();
    t_vendor();
    t_link();
    summarize();
  end
endmodule : pidp_top_tb_top
`default_nettype wire
